// >>> frs_pkg.sv
// package: shared constants and carrier types for the register scoreboard
package frs_pkg;
    localparam int unsigned REG_CNT = 52;
    localparam int unsigned ADDR_W = 6;
    localparam int unsigned DATA_W = 64;
    localparam int unsigned VLEN_W = 4;
    localparam int unsigned FU_LATENCY = 3;
    localparam logic [1:0] PH1 = 2'h0;
    localparam logic [1:0] PH2 = 2'h1;
    localparam logic [1:0] PH3 = 2'h2;
    localparam logic [1:0] PH4 = 2'h3;
    localparam logic [1:0] PH_STEP = 2'h1;
    localparam logic [3:0] VLEN_LAST = 4'h0;
    localparam logic [3:0] VLEN_STEP = 4'h1;
    localparam logic [5:0] ADDR_STEP = 6'h01;

    // alu instruction carried in the writeback-stage register
    typedef struct packed {
        logic valid;
        logic [5:0] dest;
        logic [5:0] first_source_field;
        logic [5:0] second_source_field;
        logic [3:0] vlen;
    } frs_alu_instr_t;

    // load/store/transfer instruction descriptor
    typedef struct packed {
        logic valid;
        logic is_store;
        logic to_cpu;
        logic is_load;
        logic [5:0] reg_addr;
    } frs_lst_instr_t;

    // per-cycle bypass select pair for the functional units
    typedef struct packed {
        logic first_from_result;
        logic second_from_result;
    } frs_bypass_t;

    typedef enum logic [1:0] {
        FRS_IDLE = 2'b00,
        FRS_WAIT = 2'b01,
        FRS_VEC = 2'b10
    } frs_state_t;
endpackage

// >>> frs_scoreboard.sv
// module: fpu register write-reservation scoreboard with pipeline interlocks
`timescale 1ns/100ps
// How it works
// RL1: two source reservation reads on phase 4
// RL2: set destination reservation on issue, phase 2
// RL3: clear destination reservation on retire, phase 2
// RL4: lst register reservation read on phase 2
// RL5: destinations never checked for pending writes
// RL6: load or cpu-to-fpu stalls on reserved target; the code also stalls a store or fpu-to-cpu (is_store, to_cpu)
// RL7: both source fields always checked
// RL8: software repeats first source in unary ops
// RL9: one reservation bit beside each register word
// RL10: bit select: destination phase 2, source phase 4
// RL11: same-register set and clear: set wins
// RL12: per-unit bypass selects from scoreboard
// RL13: result bus phase 1, write port phase 2
// RL14: memory read equals write address: forward
// RL15: vector elements reserved one by one
// RL16: store/fpu-to-cpu drops advance while alu waits
// RL17: load/cpu-to-fpu drops advance while alu waits
// RL18: synchronization stalls compare no addresses
// RL19: dropped writeback-advance holds all earlier stages
// RL20: software splits vectors with non-first dependences
// RL21: fixed three-cycle latency, no write port check
// RL22: pending source when valid alu blocked
// RL23: blocked alu instruction recirculates in writeback
// RL24: reset clears every reservation bit
module frs_scoreboard #(
    parameter int unsigned REGS = frs_pkg::REG_CNT,
    parameter int unsigned DW = frs_pkg::DATA_W
) (
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic alu_instr_valid_in,
    input wire frs_pkg::frs_alu_instr_t alu_instr_in,
    input wire frs_pkg::frs_lst_instr_t mem_lst_in,
    input wire frs_pkg::frs_lst_instr_t wb_lst_in,
    input wire logic writeback_advance_in,
    input wire logic [DW-1:0] result_bus_in,
    input wire logic [DW-1:0] lst_wdata_in,
    input wire logic lst_write_in,
    output logic writeback_advance_out,
    output logic memstage_advance_out,
    output logic alustage_advance_out,
    output logic fetch_advance_out,
    output logic pending_source_out,
    output logic vector_in_progress_out,
    output frs_pkg::frs_bypass_t bypass_sel_out,
    output logic [DW-1:0] mem_rdata_out,
    output logic lst_reserved_out,
    output logic [1:0] phase_out
);
    // ------------------------------------------------------------
    // reset release and four-phase sequencer
    // ------------------------------------------------------------
    logic rst_meta_ff;
    logic rst_sync_ff;
    logic [1:0] phase_ff;
    logic [1:0] nxt_phase;

    // two-stage release so every flop reset by rst_sync_ff leaves reset on the same edge
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    assign nxt_phase = phase_ff + frs_pkg::PH_STEP;

    // one machine cycle is four system clocks, phase 1 through 4
    always_ff @(posedge sys_clk_in or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
            phase_ff <= frs_pkg::PH1;
        else
            phase_ff <= nxt_phase;
    end

    wire ph1 = (phase_ff == frs_pkg::PH1);
    wire ph2 = (phase_ff == frs_pkg::PH2);
    wire ph3 = (phase_ff == frs_pkg::PH3);
    wire ph4 = (phase_ff == frs_pkg::PH4);

    // ------------------------------------------------------------
    // register file with a reservation bit on each word
    // ------------------------------------------------------------
    logic [DW-1:0] rf_mem [REGS];
    logic [REGS-1:0] resv_ff; // extra bit per register word RL9
    logic [frs_pkg::FU_LATENCY-1:0] pipe_vld_ff;
    logic [5:0] pipe_dest_ff [frs_pkg::FU_LATENCY];
    logic [DW-1:0] result_ff;
    frs_pkg::frs_alu_instr_t wb_alu_ff;
    frs_pkg::frs_state_t state_ff;
    logic src_a_resv_ff;
    logic src_b_resv_ff;

    function automatic logic resv_of(input logic [REGS-1:0] tbl, input logic [5:0] a);
        resv_of = (32'(a) < REGS) ? tbl[a] : 1'b0;
    endfunction

    wire [5:0] retire_addr = pipe_dest_ff[frs_pkg::FU_LATENCY-1];
    wire retire_vld = pipe_vld_ff[frs_pkg::FU_LATENCY-1];
    // issue only checks sources; destination is ignored on purpose RL5 RL7
    wire src_blocked = src_a_resv_ff | src_b_resv_ff; // RL7
    wire issue_now = wb_alu_ff.valid & ~src_blocked;

    // set and clear share phase 2; set wins on the same register RL11
    always_ff @(posedge sys_clk_in or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
            resv_ff <= '0; // RL24
        else if (ph2)
        begin
            for (int i = 0; i < REGS; i++)
            begin
                if (issue_now && wb_alu_ff.dest == 6'(i))
                    resv_ff[i] <= 1'b1; // RL2 RL10 RL15
                else if (retire_vld && retire_addr == 6'(i))
                    resv_ff[i] <= 1'b0; // RL3 RL11
            end
        end
    end

    // source reservation reads happen with the operand reads RL1 RL10
    always_ff @(posedge sys_clk_in or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
        begin
            src_a_resv_ff <= 1'b0;
            src_b_resv_ff <= 1'b0;
        end
        else if (ph4)
        begin
            src_a_resv_ff <= resv_of(resv_ff, wb_alu_ff.first_source_field); // RL1
            src_b_resv_ff <= resv_of(resv_ff, wb_alu_ff.second_source_field); // RL1
        end
    end

    // fixed-latency result pipe; no write-port arbitration needed RL21
    always_ff @(posedge sys_clk_in or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
            pipe_vld_ff <= '0;
        else if (ph2)
        begin
            pipe_vld_ff <= {pipe_vld_ff[frs_pkg::FU_LATENCY-2:0], issue_now}; // RL21
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (ph2)
        begin
            pipe_dest_ff[0] <= wb_alu_ff.dest;
            for (int k = 1; k < frs_pkg::FU_LATENCY; k++)
                pipe_dest_ff[k] <= pipe_dest_ff[k-1];
        end
    end

    // result bus latched on phase 1, written on phase 2 RL13
    always_ff @(posedge sys_clk_in)
    begin
        if (ph1)
            result_ff <= result_bus_in; // RL13
    end

    // result port and memory port writes; memory array has no reset
    always_ff @(posedge sys_clk_in)
    begin
        if (ph2 && retire_vld && 32'(retire_addr) < REGS)
            rf_mem[retire_addr] <= result_ff; // RL13
        if (ph2 && lst_write_in && 32'(wb_lst_in.reg_addr) < REGS)
            rf_mem[wb_lst_in.reg_addr] <= lst_wdata_in;
    end

    // memory-side read forwards the retiring result-port value being written RL14
    always_ff @(posedge sys_clk_in or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
            mem_rdata_out <= '0;
        else if (ph2)
        begin
            if (retire_vld && retire_addr == mem_lst_in.reg_addr)
                mem_rdata_out <= result_ff; // RL14
            else if (32'(mem_lst_in.reg_addr) < REGS)
                mem_rdata_out <= rf_mem[mem_lst_in.reg_addr];
            else
                mem_rdata_out <= '0;
        end
    end

    // lst reservation read port on phase 2 RL4
    always_ff @(posedge sys_clk_in or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
            lst_reserved_out <= 1'b0;
        else if (ph2)
            lst_reserved_out <= mem_lst_in.valid & resv_of(resv_ff, mem_lst_in.reg_addr); // RL4 RL6
    end

    // bypass when a source matches the retiring destination RL12
    always_ff @(posedge sys_clk_in or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
            bypass_sel_out <= '0;
        else if (ph4)
        begin
            bypass_sel_out.first_from_result <= retire_vld & (retire_addr == wb_alu_ff.first_source_field); // RL12
            bypass_sel_out.second_from_result <= retire_vld & (retire_addr == wb_alu_ff.second_source_field); // RL12
        end
    end

    // ------------------------------------------------------------
    // writeback-stage alu register and vector sequencing
    // ------------------------------------------------------------
    wire vec_more = issue_now & (wb_alu_ff.vlen != frs_pkg::VLEN_LAST);

    // blocked instruction recirculates; vectors step each element RL23 RL15
    always_ff @(posedge sys_clk_in or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
            wb_alu_ff <= '0;
        else if (ph2)
        begin
            if (wb_alu_ff.valid && src_blocked)
                wb_alu_ff <= wb_alu_ff; // RL23
            else if (vec_more)
            begin
                wb_alu_ff.dest <= wb_alu_ff.dest + frs_pkg::ADDR_STEP; // RL15
                wb_alu_ff.first_source_field <= wb_alu_ff.first_source_field + frs_pkg::ADDR_STEP;
                wb_alu_ff.second_source_field <= wb_alu_ff.second_source_field + frs_pkg::ADDR_STEP;
                wb_alu_ff.vlen <= wb_alu_ff.vlen - frs_pkg::VLEN_STEP;
            end
            else if (alu_instr_valid_in && writeback_advance_in)
                wb_alu_ff <= alu_instr_in;
            else
                wb_alu_ff <= '0;
        end
    end

    // state mirrors the alu register for observability
    always_ff @(posedge sys_clk_in or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
            state_ff <= frs_pkg::FRS_IDLE;
        else if (ph3)
        begin
            case ({wb_alu_ff.valid & src_blocked, wb_alu_ff.valid & (wb_alu_ff.vlen != frs_pkg::VLEN_LAST)})
                2'b10, 2'b11: state_ff <= frs_pkg::FRS_WAIT; // RL22
                2'b01: state_ff <= frs_pkg::FRS_VEC;
                default: state_ff <= frs_pkg::FRS_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // pipeline advance control, raised on phase 3
    // ------------------------------------------------------------
    // no address compare: cheap, may stall needlessly RL18
    wire alu_waiting = wb_alu_ff.valid & src_blocked; // RL22
    wire sync_store = alu_waiting & ((wb_lst_in.valid & wb_lst_in.is_store)
                                     | (mem_lst_in.valid & mem_lst_in.to_cpu)); // RL16 RL18
    wire sync_load = alu_waiting & mem_lst_in.valid & mem_lst_in.is_load; // RL17 RL18
    wire resv_stall = mem_lst_in.valid & (mem_lst_in.is_load | mem_lst_in.to_cpu | mem_lst_in.is_store)
                      & resv_of(resv_ff, mem_lst_in.reg_addr); // RL6
    wire drop_adv = sync_store | sync_load | resv_stall;

    // all earlier stages follow writeback-advance RL19
    always_ff @(posedge sys_clk_in or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
        begin
            writeback_advance_out <= 1'b1;
            memstage_advance_out <= 1'b1;
            alustage_advance_out <= 1'b1;
            fetch_advance_out <= 1'b1;
        end
        else if (ph3)
        begin
            writeback_advance_out <= ~drop_adv; // RL16 RL17
            memstage_advance_out <= ~drop_adv; // RL19
            alustage_advance_out <= ~drop_adv; // RL19
            fetch_advance_out <= ~drop_adv; // RL19
        end
    end

    // status outputs registered for clean timing
    always_ff @(posedge sys_clk_in or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
        begin
            pending_source_out <= 1'b0;
            vector_in_progress_out <= 1'b0;
            phase_out <= frs_pkg::PH1;
        end
        else
        begin
            pending_source_out <= (state_ff == frs_pkg::FRS_WAIT); // RL22
            vector_in_progress_out <= (state_ff == frs_pkg::FRS_VEC);
            phase_out <= phase_ff;
        end
    end
endmodule

// >>> frs_scoreboard_properties.sv
// checker: port timing relations of the reservation scoreboard
`timescale 1ns/100ps
module frs_scoreboard_properties #(parameter int unsigned DW = frs_pkg::DATA_W) (
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire frs_pkg::frs_lst_instr_t mem_lst_in,
    input wire frs_pkg::frs_lst_instr_t wb_lst_in,
    input wire logic writeback_advance_out,
    input wire logic memstage_advance_out,
    input wire logic alustage_advance_out,
    input wire logic fetch_advance_out,
    input wire logic pending_source_out,
    input wire logic vector_in_progress_out,
    input wire frs_pkg::frs_bypass_t bypass_sel_out,
    input wire logic [DW-1:0] mem_rdata_out,
    input wire logic lst_reserved_out,
    input wire logic [1:0] phase_out
);
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rstn_in);
    // one stall must freeze every stage at once
    advance_match_a: assert property (
        memstage_advance_out == writeback_advance_out && alustage_advance_out == writeback_advance_out
        && fetch_advance_out == writeback_advance_out) else $error("advance lines differ");
    phase_step_a: assert property (phase_out != frs_pkg::PH1 |=>
        phase_out == $past(phase_out) + frs_pkg::PH_STEP) else $error("phase skipped");
    reset_clear_a: assert property ($rose(rstn_in) |->
        !lst_reserved_out && !pending_source_out && !vector_in_progress_out) else $error("not clear after reset");
    // outputs move once per machine cycle, on their own phase
    advance_hold_a: assert property ($changed(writeback_advance_out) |=>
        $stable(writeback_advance_out)[*3]) else $error("advance moved twice in a cycle");
    bypass_hold_a: assert property ($changed(bypass_sel_out) |=>
        $stable(bypass_sel_out)[*3]) else $error("bypass select moved twice");
    rdata_hold_a: assert property ($changed(mem_rdata_out) |=>
        $stable(mem_rdata_out)[*3]) else $error("memory read data moved twice");
    reserved_hold_a: assert property ($changed(lst_reserved_out) |=>
        $stable(lst_reserved_out)[*3]) else $error("reserved flag moved twice");
    // pending flag is registered one clock after the advance lines, so compare against the prior sample
    store_sync_a: assert property ((pending_source_out && wb_lst_in.valid && wb_lst_in.is_store)[*8] |->
        $past(!writeback_advance_out)) else $error("store not held behind waiting alu");
    load_sync_a: assert property ((pending_source_out && mem_lst_in.valid && mem_lst_in.is_load)[*8] |->
        $past(!writeback_advance_out)) else $error("load not held behind waiting alu");
    pend_c: cover property (pending_source_out);
    vector_c: cover property (vector_in_progress_out);
    stall_c: cover property (!writeback_advance_out);
endmodule
bind frs_scoreboard frs_scoreboard_properties #(.DW(DW)) frs_scoreboard_properties_i (
    .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .mem_lst_in(mem_lst_in), .wb_lst_in(wb_lst_in),
    .writeback_advance_out(writeback_advance_out), .memstage_advance_out(memstage_advance_out),
    .alustage_advance_out(alustage_advance_out), .fetch_advance_out(fetch_advance_out),
    .pending_source_out(pending_source_out), .vector_in_progress_out(vector_in_progress_out),
    .bypass_sel_out(bypass_sel_out), .mem_rdata_out(mem_rdata_out), .lst_reserved_out(lst_reserved_out),
    .phase_out(phase_out)
);

// >>> frs_cpu_model.sv
// partner: cpu side model offering instructions once per machine cycle
`timescale 1ns/100ps
module frs_cpu_model (
    input wire logic sys_clk_in,
    input wire logic [1:0] phase_in,
    input wire logic advance_in,
    input wire frs_pkg::frs_alu_instr_t alu_req_in,
    input wire frs_pkg::frs_lst_instr_t mem_req_in,
    input wire frs_pkg::frs_lst_instr_t wb_req_in,
    input wire logic stall_req_in,
    input wire logic wr_req_in,
    output frs_pkg::frs_alu_instr_t alu_out,
    output logic alu_valid_out,
    output frs_pkg::frs_lst_instr_t mem_lst_out,
    output frs_pkg::frs_lst_instr_t wb_lst_out,
    output logic advance_out,
    output logic lst_write_out,
    output logic [63:0] result_out
);
    logic [3:0] tick = 4'h0;
    initial
    begin
        alu_out = '0;
        alu_valid_out = 1'b0;
        mem_lst_out = '0;
        wb_lst_out = '0;
        advance_out = 1'b1;
        lst_write_out = 1'b0;
    end
    // result bus changes every clock and repeats only after 16 clocks, so a sample stale by fewer than 16 clocks cannot pass
    always @(posedge sys_clk_in)
    begin
        #1;
        tick = tick + 4'h1;
        result_out = {16{tick}};
        if (phase_in == frs_pkg::PH4)
        begin
            alu_out = alu_req_in;
            alu_valid_out = alu_req_in.valid;
            advance_out = !stall_req_in;
            lst_write_out = wr_req_in;
            if (advance_in)
            begin
                mem_lst_out = mem_req_in;
                wb_lst_out = wb_req_in;
            end
        end
    end
endmodule

// >>> testbench.sv
// testbench: scoreboard driven through the cpu model, outputs checked
`timescale 1ns/100ps
module testbench;
    typedef struct packed {logic [5:0] src_a; logic [5:0] src_b; logic pend; logic [1:0] byp;} frs_row_t;
    localparam frs_row_t ROWS [4] = '{'{6'h01, 6'h01, 1'b0, 2'h0}, '{6'h05, 6'h02, 1'b1, 2'h2},
        '{6'h02, 6'h05, 1'b1, 2'h1}, '{6'h03, 6'h03, 1'b0, 2'h0}};
    localparam logic [63:0] WORD = 64'hA5C3_0F1E_7B96_2D48;
    logic sys_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic stall_req = 1'b0;
    logic wr_req = 1'b0;
    logic alu_valid, adv_in, lst_wr, wb_adv, pend, vip, reserved;
    logic [1:0] phase;
    logic [63:0] result, rdata;
    frs_pkg::frs_alu_instr_t alu_req = '0;
    frs_pkg::frs_alu_instr_t alu_in;
    frs_pkg::frs_lst_instr_t mem_req = '0;
    frs_pkg::frs_lst_instr_t wb_req = '0;
    frs_pkg::frs_lst_instr_t mem_lst, wb_lst;
    frs_pkg::frs_bypass_t bypass;
    logic seen_pend, seen_res, seen_stall, seen_vip, seen_rd;
    logic [1:0] seen_byp;
    int failures = 0;
    int tests_run = 0;
    always #50 sys_clk_in = ~sys_clk_in;
    frs_cpu_model frs_cpu_model_i (.sys_clk_in(sys_clk_in), .phase_in(phase), .advance_in(wb_adv),
        .alu_req_in(alu_req), .mem_req_in(mem_req), .wb_req_in(wb_req), .stall_req_in(stall_req),
        .wr_req_in(wr_req), .alu_out(alu_in), .alu_valid_out(alu_valid), .mem_lst_out(mem_lst),
        .wb_lst_out(wb_lst), .advance_out(adv_in), .lst_write_out(lst_wr), .result_out(result));
    frs_scoreboard frs_scoreboard_i (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .alu_instr_valid_in(alu_valid),
        .alu_instr_in(alu_in), .mem_lst_in(mem_lst), .wb_lst_in(wb_lst), .writeback_advance_in(adv_in),
        .result_bus_in(result), .lst_wdata_in(WORD), .lst_write_in(lst_wr), .writeback_advance_out(wb_adv),
        .memstage_advance_out(), .alustage_advance_out(), .fetch_advance_out(), .pending_source_out(pend),
        .vector_in_progress_out(vip), .bypass_sel_out(bypass), .mem_rdata_out(rdata),
        .lst_reserved_out(reserved), .phase_out(phase));
    // sticky flags: some interesting outputs, such as the bypass selects, stand for only one machine cycle
    always @(posedge sys_clk_in)
    begin
        seen_pend |= pend;
        seen_res |= reserved;
        seen_stall |= !wb_adv;
        seen_vip |= vip;
        seen_rd |= (rdata === WORD);
        seen_byp |= bypass;
    end
    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
        if (n == 0)
            {seen_pend, seen_res, seen_stall, seen_vip, seen_rd, seen_byp} = '0;
    endtask
    // one alu offer spans exactly one model capture
    task automatic offer(input logic [5:0] d, input logic [5:0] a, input logic [5:0] b, input logic [3:0] v);
        alu_req = '{1'b1, d, a, b, v};
        step(4);
        alu_req = '0;
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // watchdog: the sequence needs well under 2000 clocks
    initial
    begin
        #400000;
        failures++;
        print_verdict();
    end
    initial
    begin
        repeat (4) @(posedge sys_clk_in);
        #1 rstn_in = 1'b1;
        step(3);
        check("advance", wb_adv, 1'b1);
        check("reserved", reserved, 1'b0);
        check("pending", {pend, vip, bypass}, 4'h0);
        $display("reset test done");
        foreach (ROWS[i])
        begin
            step(0);
            offer(6'h05, 6'h0A, 6'h0A, 4'h0);
            offer(6'h05, ROWS[i].src_a, ROWS[i].src_b, 4'h0);
            step(12);
            check("row pending", seen_pend, ROWS[i].pend);
            check("row bypass", seen_byp, ROWS[i].byp);
            step(24);
            check("drained", pend, 1'b0);
            $display("row %0d done", i);
        end
        step(0);
        offer(6'h07, 6'h0A, 6'h0A, 4'h0);
        mem_req = '{1'b1, 1'b0, 1'b0, 1'b1, 6'h07};
        step(16);
        check("load reserved", seen_res, 1'b1);
        check("load stall", seen_stall, 1'b1);
        step(24);
        check("retired", {wb_adv, reserved}, 2'h2);
        mem_req = '0;
        $display("load test done");
        step(0);
        offer(6'h08, 6'h0A, 6'h0A, 4'h0);
        wb_req = '{1'b1, 1'b1, 1'b0, 1'b0, 6'h21};
        mem_req = '{1'b1, 1'b0, 1'b0, 1'b1, 6'h22};
        offer(6'h09, 6'h08, 6'h08, 4'h0);
        step(8);
        check("sync pending", seen_pend, 1'b1);
        check("store stall", seen_stall, 1'b1);
        {wb_req, mem_req} = '0;
        step(32);
        $display("store test done");
        step(0);
        // sources kept clear of the result registers so elements issue back to back
        offer(6'h0C, 6'h00, 6'h00, 4'h2);
        // late-element read: only its own reservation protects it
        mem_req = '{1'b1, 1'b0, 1'b1, 1'b0, 6'h0E};
        step(24);
        check("vector busy", seen_vip, 1'b1);
        check("last element", seen_res, 1'b1);
        mem_req = '0;
        step(24);
        stall_req = 1'b1;
        step(0);
        offer(6'h32, 6'h0A, 6'h0A, 4'h0);
        mem_req = '{1'b1, 1'b0, 1'b0, 1'b1, 6'h32};
        step(16);
        check("held issue", seen_res, 1'b0);
        {stall_req, mem_req} = '0;
        step(8);
        $display("vector and stall tests done");
        wb_req = '{1'b1, 1'b0, 1'b0, 1'b1, 6'h28};
        wr_req = 1'b1;
        step(4);
        wr_req = 1'b0;
        wb_req = '{1'b1, 1'b1, 1'b0, 1'b0, 6'h28};
        mem_req = '{1'b1, 1'b0, 1'b1, 1'b0, 6'h28};
        step(0);
        step(12);
        check("read back", seen_rd, 1'b1);
        $display("read test done");
        // retire into the register the transfer reads: the forwarded word must win over the old one
        step(0);
        offer(6'h28, 6'h0A, 6'h0A, 4'h0);
        step(17);
        // model result bus carries tick 6 in the latching clock
        check("forwarded", rdata, {16{4'h6}});
        $display("forward test done");
        print_verdict();
    end
endmodule
